/* File: rtl/nsw_pkg.sv */
package nsw_pkg;

  localparam int PADDR_W = 18;
  localparam logic [15:0] IDX_ADDRESS = 16'h1c8c;
  localparam logic [15:0] IDX_DATA = 16'h1c8e;
  localparam logic [15:0] IDX_CONTROL = 16'h1c90;
  localparam logic [15:0] IDX_KEY = 16'h1c91;

  localparam int CTL_RD = 0;
  localparam int CTL_WR = 1;
  localparam int CTL_PROGRAM_ERASE_ENABLE = 2;
  localparam int CTL_WRITE_ERROR_FLAG = 3;
  localparam int CTL_FREE = 4;
  localparam int CTL_LATCH_LOAD_ONLY = 5;
  localparam int CTL_REGS = 6;
  localparam logic [7:0] CTL_RESET = 8'h00;

  localparam logic [7:0] KEY_FIRST = 8'h55;
  localparam logic [7:0] KEY_SECOND = 8'haa;

  localparam int ROW_WORDS = 32;
  localparam int WORD_W = 14;
  localparam int NVA_W = 15;
  localparam logic [13:0] LATCH_BLANK = 14'h3fff;
  localparam logic [14:0] ADDR_RESET = 15'h0000;
  localparam logic [13:0] DATA_RESET = 14'h0000;

  localparam logic [14:0] UID_LO = 15'h0000;
  localparam logic [14:0] UID_HI = 15'h0003;
  localparam logic [14:0] DEVID_LO = 15'h0005;
  localparam logic [14:0] DEVID_HI = 15'h0006;
  localparam logic [14:0] CFG_LO = 15'h0007;
  localparam logic [14:0] CFG_HI = 15'h000b;
  localparam logic [14:0] DIA_LO = 15'h0100;
  localparam logic [14:0] DIA_HI = 15'h02ff;

  typedef enum logic [1:0] {CMD_READ, CMD_ERASE, CMD_WRITE} nsw_cmd_t;
  typedef enum logic [1:0] {ST_IDLE, ST_READ, ST_PROG} nsw_state_t;
  typedef enum logic [1:0] {KEY_IDLE, KEY_ONE, KEY_ARMED} nsw_key_t;

  typedef struct packed {
    logic req;
    nsw_cmd_t cmd;
    logic [15:0] addr;
    logic [ROW_WORDS-1:0][WORD_W-1:0] row;
  } nsw_flash_req_t;

  typedef struct packed {
    logic done;
    logic [WORD_W-1:0] rdata;
    logic wp;
  } nsw_flash_rsp_t;

  typedef struct packed {
    nsw_state_t st;
    nsw_key_t key;
    logic [NVA_W-1:0] adr;
    logic [WORD_W-1:0] dat;
    logic [7:0] ctl;
    logic [31:0] rdat;
    logic rdy;
    logic err;
    nsw_flash_req_t fl;
  } nsw_regs_t;

  localparam nsw_regs_t NSW_RESET = '{
    st: ST_IDLE, key: KEY_IDLE, adr: ADDR_RESET, dat: DATA_RESET, ctl: CTL_RESET,
    rdat: 32'h0000_0000, rdy: 1'b0, err: 1'b0,
    fl: '{req: 1'b0, cmd: CMD_READ, addr: 16'h0000, row: {ROW_WORDS{LATCH_BLANK}}}
  };

endpackage

/* File: rtl/nsw_nvm_self_write_control.sv */
`timescale 1ns/1ps

// Behaviour
// R1 - 15-bit address, separate high/low bytes
// R2 - address bit 15 undefined while busy
// R3 - 14-bit data, separate bytes, unknown reset
// R4 - bit 6 selects info area or flash
// R5 - latch-only loads addressed write latch
// R6 - latch-only clear programs row; erase overrides
// R7 - bit 4 erases 32-word row
// R8 - bit 3 flags failed write
// R9 - hardware never clears error flag
// R10 - software may set error flag
// R11 - error flag undefined while busy
// R12 - bit 2 gates program and erase
// R13 - trigger set only right after unlock
// R14 - self-timed; hardware clears trigger
// R15 - writing trigger zero never aborts
// R16 - read bit starts read, hardware clears
// R17 - unlock needs 0x55 then 0xaa
// R18 - interrupted unlock starts nothing
// R19 - protected target: clear trigger, set error
// R20 - latches blank after erase or write
// R21 - invalid info read clears data
// R22 - unlock steps on consecutive accesses only
// R23 - unlock register reads zero
module nsw_nvm_self_write_control
  import nsw_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [PADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output nsw_flash_req_t fl_o,
  input wire nsw_flash_rsp_t fl_i
);

  nsw_regs_t q;
  nsw_regs_t d;

  // bus decode
  logic [15:0] idx;
  logic hit_adr;
  logic hit_dat;
  logic hit_ctl;
  logic hit_key;
  logic hit_any;
  logic wait_cyc;
  logic acc;
  logic wr_acc;
  logic adr_wr;
  logic dat_wr;
  logic ctl_wr;
  logic key_wr;
  logic adr_lo_wr;
  logic adr_hi_wr;
  logic dat_lo_wr;
  logic dat_hi_wr;
  logic [7:0] cw;
  logic [31:0] rd_word;

  // info region windows
  logic in_uid;
  logic in_devid;
  logic in_cfg;
  logic in_dia;
  logic info_rd_ok;
  logic info_wr_ok;

  // control bits after this cycle's write
  logic nx_regs;
  logic nx_latch_load_only;
  logic nx_program_erase_enable;
  logic nx_free;
  logic nx_rd;

  // engine and unlock events
  logic eng_idle;
  logic rd_done;
  logic pg_done;
  logic key_first;
  logic key_second;

  // start decisions
  logic trig_go;
  logic latch_only;
  logic target_locked;
  logic start_latch;
  logic start_fail;
  logic start_prog;
  logic rd_try;
  logic rd_void;
  logic start_read;

  assign idx = paddr[PADDR_W-1:2];
  assign hit_adr = idx == IDX_ADDRESS;
  assign hit_dat = idx == IDX_DATA;
  assign hit_ctl = idx == IDX_CONTROL;
  assign hit_key = idx == IDX_KEY;
  assign hit_any = hit_adr | hit_dat | hit_ctl | hit_key;

  // one wait state, then the access completes
  assign wait_cyc = psel & penable & ~q.rdy;
  assign acc = psel & penable & q.rdy;
  assign wr_acc = acc & pwrite;

  // byte lane strobes
  assign adr_wr = wr_acc & hit_adr;
  assign dat_wr = wr_acc & hit_dat;
  assign ctl_wr = wr_acc & hit_ctl & pstrb[0];
  assign key_wr = wr_acc & hit_key & pstrb[0];
  assign adr_lo_wr = adr_wr & pstrb[0];
  assign adr_hi_wr = adr_wr & pstrb[1];
  assign dat_lo_wr = dat_wr & pstrb[0];
  assign dat_hi_wr = dat_wr & pstrb[1];
  assign cw = pwdata[7:0];

  // info region legality
  assign in_uid = (q.adr >= UID_LO) && (q.adr <= UID_HI);
  assign in_devid = (q.adr >= DEVID_LO) && (q.adr <= DEVID_HI);
  assign in_cfg = (q.adr >= CFG_LO) && (q.adr <= CFG_HI);
  assign in_dia = (q.adr >= DIA_LO) && (q.adr <= DIA_HI);
  assign info_wr_ok = in_uid | in_cfg;
  assign info_rd_ok = in_uid | in_devid | in_cfg | in_dia;

  // next control bits; free and rd are set-only, software cannot clear them
  assign nx_regs = ctl_wr ? cw[CTL_REGS] : q.ctl[CTL_REGS];
  assign nx_latch_load_only = ctl_wr ? cw[CTL_LATCH_LOAD_ONLY] : q.ctl[CTL_LATCH_LOAD_ONLY];
  assign nx_program_erase_enable = ctl_wr ? cw[CTL_PROGRAM_ERASE_ENABLE] : q.ctl[CTL_PROGRAM_ERASE_ENABLE];
  assign nx_free = q.ctl[CTL_FREE] | (ctl_wr & cw[CTL_FREE]);
  assign nx_rd = q.ctl[CTL_RD] | (ctl_wr & cw[CTL_RD]);

  // engine state and unlock steps
  assign eng_idle = q.st == ST_IDLE;
  assign rd_done = (q.st == ST_READ) & fl_i.done;
  assign pg_done = (q.st == ST_PROG) & fl_i.done;
  assign key_first = key_wr & (cw == KEY_FIRST); // [R17]
  assign key_second = key_wr & (cw == KEY_SECOND) & (q.key == KEY_ONE); // [R17]

  // a zero written to the trigger never starts or stops anything
  assign trig_go = ctl_wr & cw[CTL_WR] & (q.key == KEY_ARMED) & nx_program_erase_enable & eng_idle; // [R13] [R12] [R15]
  assign latch_only = ~nx_free & nx_latch_load_only; // [R5] [R6]
  assign target_locked = nx_regs ? ~info_wr_ok : fl_i.wp; // [R19]
  assign start_latch = trig_go & latch_only;
  assign start_fail = trig_go & ~latch_only & target_locked;
  assign start_prog = trig_go & ~latch_only & ~target_locked;

  // a pending read waits for the engine
  assign rd_try = ~trig_go & nx_rd & eng_idle;
  assign rd_void = rd_try & nx_regs & ~info_rd_ok; // [R21]
  assign start_read = rd_try & ~rd_void;

  // read mux
  always_comb
  begin
    rd_word = 32'h0000_0000;
    if (hit_adr)
    begin
      rd_word[NVA_W-1:0] = q.adr; // [R1] [R2]
    end
    if (hit_dat)
    begin
      rd_word[WORD_W-1:0] = q.dat; // [R3]
    end
    if (hit_ctl)
    begin
      rd_word[6:0] = q.ctl[6:0]; // [R11]
    end
    if (hit_key)
    begin
      rd_word = 32'h0000_0000; // [R23]
    end
  end

  always_comb
  begin
    d = q;

    // apb answer
    d.rdy = wait_cyc;
    d.err = 1'b0;
    if (wait_cyc)
    begin
      d.err = ~hit_any;
      d.rdat = rd_word;
    end

    // address byte lanes
    if (adr_lo_wr)
    begin
      d.adr[7:0] = pwdata[7:0]; // [R1]
    end
    if (adr_hi_wr)
    begin
      d.adr[14:8] = pwdata[14:8]; // [R1]
    end

    // data byte lanes
    if (dat_lo_wr)
    begin
      d.dat[7:0] = pwdata[7:0]; // [R3]
    end
    if (dat_hi_wr)
    begin
      d.dat[13:8] = pwdata[13:8]; // [R3]
    end

    // control writes; trigger only through unlock
    if (ctl_wr)
    begin
      d.ctl[CTL_REGS] = nx_regs; // [R4]
      d.ctl[CTL_LATCH_LOAD_ONLY] = nx_latch_load_only; // [R5]
      d.ctl[CTL_FREE] = nx_free; // [R7]
      d.ctl[CTL_WRITE_ERROR_FLAG] = cw[CTL_WRITE_ERROR_FLAG]; // [R9] [R10]
      d.ctl[CTL_PROGRAM_ERASE_ENABLE] = nx_program_erase_enable; // [R12]
      d.ctl[CTL_RD] = nx_rd; // [R16]
    end

    // unlock sequencing
    if (acc)
    begin
      d.key = KEY_IDLE; // [R22] [R18]
    end
    if (key_first)
    begin
      d.key = KEY_ONE; // [R17]
    end
    else if (key_second)
    begin
      d.key = KEY_ARMED; // [R17]
    end

    // completion of self-timed operations
    unique case (q.st)
      ST_IDLE:
      begin
        d.st = ST_IDLE;
      end
      ST_READ:
      begin
        if (rd_done)
        begin
          d.dat = fl_i.rdata;
          d.ctl[CTL_RD] = 1'b0; // [R16]
          d.fl.req = 1'b0;
          d.st = ST_IDLE;
        end
      end
      ST_PROG:
      begin
        if (pg_done)
        begin
          d.ctl[CTL_WR] = 1'b0; // [R14]
          if (q.fl.cmd == CMD_ERASE)
          begin
            d.ctl[CTL_FREE] = 1'b0; // [R7]
          end
          d.fl.row = {ROW_WORDS{LATCH_BLANK}}; // [R20]
          d.fl.req = 1'b0;
          d.st = ST_IDLE;
        end
      end
      default:
      begin
        d.st = ST_IDLE;
        d.fl.req = 1'b0;
      end
    endcase

    // latch load; no memory access, protection ignored
    if (start_latch)
    begin
      d.fl.row[q.adr[4:0]] = q.dat; // [R5]
    end

    // protected target refused; set wins over a clear
    if (start_fail)
    begin
      d.ctl[CTL_WR] = 1'b0; // [R19]
      d.ctl[CTL_WRITE_ERROR_FLAG] = 1'b1; // [R8] [R19]
    end

    // erase or row write launch
    if (start_prog)
    begin
      d.ctl[CTL_WR] = 1'b1; // [R14]
      d.st = ST_PROG;
      d.fl.req = 1'b1;
      d.fl.cmd = nx_free ? CMD_ERASE : CMD_WRITE; // [R6] [R7]
      d.fl.addr = {nx_regs, q.adr}; // [R4]
    end

    // info read outside valid windows
    if (rd_void)
    begin
      d.dat = DATA_RESET; // [R21]
      d.ctl[CTL_RD] = 1'b0; // [R16]
    end

    // flash read launch
    if (start_read)
    begin
      d.st = ST_READ; // [R16]
      d.fl.req = 1'b1;
      d.fl.cmd = CMD_READ;
      d.fl.addr = {nx_regs, q.adr}; // [R4]
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      q <= NSW_RESET;
    else
      q <= d;
  end

  assign prdata = q.rdat;
  assign pready = q.rdy;
  assign pslverr = q.err;
  assign fl_o = q.fl;

endmodule

/* File: verification/nsw_flash_model.sv */
`timescale 1ns/1ps
module nsw_flash_model
  import nsw_pkg::*;
#(
  parameter int LAT = 3
)
(
  input logic pclk,
  input logic presetn,
  input nsw_flash_req_t fl_o,
  input logic wp,
  output nsw_flash_rsp_t fl_i
);
  logic [3:0] n_q;
  logic done;
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      n_q <= '0;
    else
      n_q <= fl_o.req && !fl_i.done ? n_q + 4'h1 : '0;
  assign done = fl_o.req && n_q == LAT;
  // idle bus shows inverse, not stale data
  assign fl_i = '{done: done, rdata: done ? fl_o.addr[13:0] ^ 14'h2a5a : ~fl_o.addr[13:0], wp: wp};
endmodule

/* File: verification/nsw_props.sv */
`timescale 1ns/1ps
module nsw_props
  import nsw_pkg::*;
(
  input logic pclk,
  input logic presetn,
  input logic pwrite,
  input logic [PADDR_W-1:0] paddr,
  input logic [31:0] prdata,
  input logic pready,
  input logic pslverr,
  input nsw_flash_req_t fl_o,
  input nsw_flash_rsp_t fl_i
);
  default clocking @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  wire rd = pready && !pwrite;
  a_data_width: assert property (rd && paddr == 18'h07238 |-> prdata[31:14] == '0) else $error("data");
  a_key_zero: assert property (rd && paddr == 18'h07244 |-> prdata == '0) else $error("key");
  a_ready_pulse: assert property (pready |=> !pready) else $error("ready");
  a_slv_ready: assert property (pslverr |-> pready) else $error("slverr");
  a_req_cause: assert property ($rose(fl_o.req) && fl_o.cmd != CMD_READ |-> $past(pready && pwrite))
    else $error("start");
  a_req_hold: assert property (fl_o.req && !fl_i.done && !$past(fl_i.done) |=> fl_o.req && $stable(fl_o.addr))
    else $error("hold");
  a_req_end: assert property (fl_o.req && fl_i.done |-> ##[1:2] !fl_o.req) else $error("end");
  a_row_blank: assert property (fl_o.req && fl_i.done && fl_o.cmd != CMD_READ |->
    ##[1:2] fl_o.row == {ROW_WORDS{LATCH_BLANK}}) else $error("blank");
endmodule
bind nsw_nvm_self_write_control nsw_props u_nsw_props (.*);

/* File: verification/tb_nsw_nvm_self_write_control.sv */
`timescale 1ns/1ps
module tb_nsw_nvm_self_write_control;
  import nsw_pkg::*;
  logic pclk = '0, presetn = '0, psel = '0, penable = '0, pwrite = '0, wp = '0, err, pready, pslverr;
  logic [17:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd;
  logic [3:0] pstrb = 4'h3;
  nsw_flash_req_t fl_o;
  nsw_flash_rsp_t fl_i;
  int n_errors = 0, comparisons = 0;
  localparam logic [17:0] A = 18'h07230, D = 18'h07238, C = 18'h07240, K = 18'h07244;
  nsw_nvm_self_write_control u_nsw_nvm_self_write_control (
    .pclk(pclk),
    .presetn(presetn),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .pstrb(pstrb),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .fl_o(fl_o),
    .fl_i(fl_i)
  );
  nsw_flash_model u_nsw_flash_model (
    .pclk(pclk),
    .presetn(presetn),
    .fl_o(fl_o),
    .wp(wp),
    .fl_i(fl_i)
  );
  initial forever #50 pclk = ~pclk;
  task automatic chk(string n, logic [31:0] e, logic [31:0] s);
    comparisons++;
    if (s !== e)
    begin
      n_errors++;
      $display("ERROR %s exp %h got %h", n, e, s);
    end
  endtask
  task automatic apb(logic w, logic [17:0] a, logic [31:0] d);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    do
      @(posedge pclk);
    while (!pready);
    rd = prdata;
    err = pslverr;
    psel <= '0;
    penable <= '0;
    @(posedge pclk);
  endtask
  task automatic rc(logic [17:0] a, logic [31:0] e, string n);
    apb('0, a, '0);
    chk(n, e, rd);
  endtask
  task automatic go(logic [31:0] c);
    apb(1'h1, K, 32'h55);
    apb(1'h1, K, 32'haa);
    apb(1'h1, C, c);
  endtask
  task automatic idle;
    while (fl_o.req) @(posedge pclk);
  endtask
  task automatic t_info;
    apb(1'h1, A, 32'h4);
    apb(1'h1, C, 32'h41);
    chk("ireq", '0, fl_o.req);
    rc(D, '0, "void");
    rc(C, 32'h40, "iregs");
  endtask
  task automatic t_read;
    apb(1'h1, A, 32'h5);
    apb(1'h1, C, 32'h1);
    idle;
    rc(D, 32'h2a5f, "rd");
    apb('0, 18'h00100, '0);
    chk("slv", 1'h1, err);
  endtask
  task automatic t_prog;
    apb(1'h1, A, 32'h23);
    apb(1'h1, D, 32'h1abc);
    go(32'h26);
    chk("latch", 32'h1abc, fl_o.row[3]);
    go(32'h06);
    chk("cmd", CMD_WRITE, fl_o.cmd);
    chk("addr", 32'h0023, fl_o.addr);
    idle;
    chk("blank", 32'h3fff, fl_o.row[3]);
    go(32'h16);
    idle;
    rc(C, 32'h04, "free");
  endtask
  task automatic t_lock;
    apb(1'h1, K, 32'h55);
    rc(K, '0, "key");
    apb(1'h1, K, 32'haa);
    apb(1'h1, C, 32'h06);
    chk("break", '0, fl_o.req);
    wp <= 1'h1;
    go(32'h06);
    rc(C, 32'h0c, "prot");
    apb(1'h1, C, 32'h04);
    rc(C, 32'h04, "clr");
    apb(1'h1, C, 32'h0c);
    rc(C, 32'h0c, "set");
  endtask
  task automatic conclude;
    $display("n_errors %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  initial
  begin
    repeat (12) @(posedge pclk);
    presetn <= 1'h1;
    @(posedge pclk);
    t_read;
    t_info;
    t_prog;
    t_lock;
    conclude;
  end
  initial
  begin
    #2000000;
    n_errors++;
    conclude;
  end
endmodule
